//--- hw/ubp_pkg.sv
package ubp_pkg;
  // Attribute type codes; types 4..13 are consecutive
  localparam logic [7:0] TYP_PRE_OFF = 8'h04;
  localparam logic [7:0] TYP_FEC_T = 8'h05;
  localparam logic [7:0] TYP_INFO_K = 8'h06;
  localparam logic [7:0] TYP_SEED = 8'h07;
  localparam logic [7:0] TYP_MAX_BURST = 8'h08;
  localparam logic [7:0] TYP_GUARD = 8'h09;
  localparam logic [7:0] TYP_LAST_CW = 8'h0A;
  localparam logic [7:0] TYP_SCR = 8'h0B;
  localparam logic [7:0] TYP_DEPTH = 8'h0C;
  localparam logic [7:0] TYP_BLOCK = 8'h0D;
  localparam logic [3:0] ATTR_COUNT = 4'hA;
  localparam logic [3:0] IDX_GUARD = 4'h5;
  localparam logic [3:0] IDX_SCR = 4'h7;
  localparam logic [3:0] IDX_DEPTH = 4'h8;
  localparam logic [3:0] IDX_BLOCK = 4'h9;
  // Value limits
  localparam logic [4:0] T_MAX_EXT = 5'h10;
  localparam logic [4:0] T_MAX_LEG = 5'h0A;
  localparam logic [7:0] K_MIN = 8'h10;
  localparam logic [7:0] K_MAX = 8'hFD;
  localparam logic [16:0] INTLV_SPAN = 17'h00800;
  localparam logic [15:0] BLOCK_MAX = 16'h0800;
  localparam logic [7:0] SEL_ONE = 8'h01;
  localparam logic [7:0] SEL_TWO = 8'h02;
  // Head-end register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PRE_OFF = 8'h08;
  localparam logic [7:0] REG_FEC = 8'h0C;
  localparam logic [7:0] REG_SEED = 8'h10;
  localparam logic [7:0] REG_BURST = 8'h14;
  localparam logic [7:0] REG_MODE = 8'h18;
  localparam logic [7:0] REG_INTLV = 8'h1C;
  localparam logic [31:0] MASK_CTRL = 32'h0000007E;
  localparam logic [31:0] MASK_PRE_OFF = 32'h0000FFFF;
  localparam logic [31:0] MASK_FEC = 32'h0000FF1F;
  localparam logic [31:0] MASK_SEED = 32'h00007FFF;
  localparam logic [31:0] MASK_HALF = 32'h0000FFFF;
  localparam logic [31:0] MASK_INTLV = 32'hFFFF00FF;
  localparam logic [31:0] RST_MODE = 32'h00000101;
  localparam int CTRL_START = 0;
  localparam int CTRL_EXT = 1;
  localparam int CTRL_CDMA = 2;
  localparam int CTRL_SHORT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {RX_TYPE = 2'b00, RX_LEN = 2'b01, RX_VAL = 2'b10} ubp_rx_state_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_LOAD = 2'b01, TX_SEND = 2'b10} ubp_tx_state_t;
endpackage

//--- hw/ubp_link_if.sv
`timescale 1ns/10ps
interface ubp_link_if;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_data;
  logic tx_last;
  logic ext_format;
  logic code_div;
  modport dev (input tx_valid, input tx_data, input tx_last, input ext_format,
    input code_div, output tx_ready);
  modport head (output tx_valid, output tx_data, output tx_last, output ext_format,
    output code_div, input tx_ready);
endinterface

//--- hw/ubp_burst_decoder.sv
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module ubp_burst_decoder (
  input wire logic aclk,
  input wire logic aresetn,
  ubp_link_if.dev link,
  output logic cfg_valid,
  output logic cfg_error,
  output logic [15:0] cfg_preamble_start,
  output logic cfg_fec_enable,
  output logic [5:0] cfg_parity_bytes,
  output logic [7:0] cfg_info_bytes,
  output logic [8:0] codeword_total_bytes,
  output logic [14:0] cfg_scrambler_seed,
  output logic cfg_scrambler_enable,
  output logic cfg_burst_limit_enable,
  output logic [7:0] cfg_max_burst_minislots,
  output logic [7:0] cfg_guard_symbols,
  output logic cfg_last_cw_shortened,
  output logic cfg_interleave_dynamic,
  output logic [7:0] interleave_depth,
  output logic [15:0] interleave_block_size
);
  ubp_pkg::ubp_rx_state_t state_reg;
  logic ready_reg;
  logic [7:0] type_reg;
  logic [7:0] len_reg;
  logic [7:0] cnt_reg;
  logic [7:0] acc_reg;
  logic eval_reg;
  logic ext_reg;
  logic cdma_reg;
  logic trunc_reg;
  logic [15:0] sh_off;
  logic [4:0] sh_t;
  logic [7:0] sh_k;
  logic [14:0] sh_seed;
  logic [7:0] sh_max;
  logic sh_max_seen;
  logic [7:0] sh_guard;
  logic [7:0] sh_last;
  logic [7:0] sh_scr;
  logic [7:0] sh_depth;
  logic [15:0] sh_block;
  logic hs;
  logic commit;
  logic [15:0] val;
  logic fec_on;
  logic [8:0] total;
  logic [16:0] span;
  logic err;

  assign link.tx_ready = ready_reg;
  assign hs = link.tx_valid && ready_reg;
  // A value completes on its last byte; two-byte values come high byte first
  assign commit = hs && state_reg == ubp_pkg::RX_VAL && cnt_reg == len_reg - 8'h01;
  assign val = {acc_reg, link.tx_data};

  // Ready drops for the evaluation cycle so shadows are not hit mid-publish
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ready_reg <= 1'b0;
    else
      ready_reg <= !(hs && link.tx_last);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ubp_pkg::RX_TYPE;
      type_reg <= 8'h00;
      len_reg <= 8'h00;
      cnt_reg <= 8'h00;
      acc_reg <= 8'h00;
    end
    else if (hs)
    begin
      unique case (state_reg)
        ubp_pkg::RX_TYPE:
        begin
          type_reg <= link.tx_data;
          state_reg <= link.tx_last ? ubp_pkg::RX_TYPE : ubp_pkg::RX_LEN;
        end
        ubp_pkg::RX_LEN:
        begin
          len_reg <= link.tx_data;
          cnt_reg <= 8'h00;
          acc_reg <= 8'h00;
          state_reg <= (link.tx_data == 8'h00 || link.tx_last) ? ubp_pkg::RX_TYPE
            : ubp_pkg::RX_VAL;
        end
        ubp_pkg::RX_VAL:
        begin
          acc_reg <= link.tx_data;
          cnt_reg <= cnt_reg + 8'h01;
          if (commit || link.tx_last)
            state_reg <= ubp_pkg::RX_TYPE;
        end
        default:
          state_reg <= ubp_pkg::RX_TYPE;
      endcase
    end
  end

  // Descriptor end: latch format flags, note a cut-off attribute
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      eval_reg <= 1'b0;
      ext_reg <= 1'b0;
      cdma_reg <= 1'b0;
      trunc_reg <= 1'b0;
    end
    else
    begin
      eval_reg <= hs && link.tx_last;
      if (hs && link.tx_last)
      begin
        ext_reg <= link.ext_format;
        cdma_reg <= link.code_div;
        trunc_reg <= state_reg != ubp_pkg::RX_TYPE && !commit
          && !(state_reg == ubp_pkg::RX_LEN && link.tx_data == 8'h00);
      end
    end
  end

  // Shadow fields; cleared to absent after each publish
  always_ff @(posedge aclk)
  begin
    if (!aresetn || eval_reg)
    begin
      sh_off <= 16'h0000;
      sh_t <= 5'h00;
      sh_k <= 8'h00;
      sh_seed <= 15'h0000;
      sh_max <= 8'h00;
      sh_max_seen <= 1'b0;
      sh_guard <= 8'h00;
      sh_last <= ubp_pkg::SEL_ONE;
      sh_scr <= ubp_pkg::SEL_ONE;
      sh_depth <= 8'h00;
      sh_block <= 16'h0000;
    end
    else if (commit)
    begin
      unique case (type_reg)
        ubp_pkg::TYP_PRE_OFF: sh_off <= val;
        ubp_pkg::TYP_FEC_T: sh_t <= (val[7:5] != 3'h0) ? 5'h1F : val[4:0];
        ubp_pkg::TYP_INFO_K: sh_k <= val[7:0];
        ubp_pkg::TYP_SEED: sh_seed <= val[15:1];
        ubp_pkg::TYP_MAX_BURST:
        begin
          sh_max <= val[7:0];
          sh_max_seen <= 1'b1;
        end
        // Guard does not exist on code-division channels
        ubp_pkg::TYP_GUARD: sh_guard <= link.code_div ? 8'h00 : val[7:0];
        ubp_pkg::TYP_LAST_CW: sh_last <= val[7:0];
        ubp_pkg::TYP_SCR: sh_scr <= val[7:0];
        ubp_pkg::TYP_DEPTH: sh_depth <= val[7:0];
        ubp_pkg::TYP_BLOCK: sh_block <= val;
        default: sh_off <= sh_off;
      endcase
    end
  end

  // Checks; the span test avoids a divider: depth*(k+2T) <= 2048
  always_comb
  begin
    fec_on = sh_t != 5'h00;
    total = fec_on ? 9'(sh_k) + 9'({sh_t, 1'b0}) : 9'h000;
    span = 17'(sh_depth) * 17'(total);
    err = trunc_reg;
    if (sh_t > (ext_reg ? ubp_pkg::T_MAX_EXT : ubp_pkg::T_MAX_LEG))
      err = 1'b1;
    if (fec_on && (sh_k < ubp_pkg::K_MIN || sh_k > ubp_pkg::K_MAX))
      err = 1'b1;
    if (sh_last != ubp_pkg::SEL_ONE && sh_last != ubp_pkg::SEL_TWO)
      err = 1'b1;
    if (sh_scr != ubp_pkg::SEL_ONE && sh_scr != ubp_pkg::SEL_TWO)
      err = 1'b1;
    if (span > ubp_pkg::INTLV_SPAN)
      err = 1'b1;
    if (sh_depth == 8'h00 && sh_block > ubp_pkg::BLOCK_MAX)
      err = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_valid <= 1'b0;
      cfg_error <= 1'b0;
    end
    else
    begin
      cfg_valid <= eval_reg && !err;
      cfg_error <= eval_reg && err;
    end
  end

  // A rejected descriptor leaves the previous configuration in force
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_preamble_start <= 16'h0000;
      cfg_fec_enable <= 1'b0;
      cfg_parity_bytes <= 6'h00;
      cfg_info_bytes <= 8'h00;
      codeword_total_bytes <= 9'h000;
      cfg_scrambler_seed <= 15'h0000;
      cfg_scrambler_enable <= 1'b0;
      cfg_burst_limit_enable <= 1'b0;
      cfg_max_burst_minislots <= 8'h00;
      cfg_guard_symbols <= 8'h00;
      cfg_last_cw_shortened <= 1'b0;
      cfg_interleave_dynamic <= 1'b0;
      interleave_depth <= 8'h00;
      interleave_block_size <= 16'h0000;
    end
    else if (eval_reg && !err)
    begin
      // Superstring bit index that the mapper takes as I1 of symbol one
      cfg_preamble_start <= sh_off;
      cfg_fec_enable <= fec_on;
      cfg_parity_bytes <= {sh_t, 1'b0};
      cfg_info_bytes <= fec_on ? sh_k : 8'h00;
      codeword_total_bytes <= total;
      cfg_scrambler_seed <= sh_seed;
      cfg_scrambler_enable <= sh_scr == ubp_pkg::SEL_ONE;
      cfg_burst_limit_enable <= sh_max_seen;
      cfg_max_burst_minislots <= sh_max;
      cfg_guard_symbols <= cdma_reg ? 8'h00 : sh_guard;
      cfg_last_cw_shortened <= sh_last == ubp_pkg::SEL_TWO;
      cfg_interleave_dynamic <= sh_depth == 8'h00;
      interleave_depth <= sh_depth;
      interleave_block_size <= sh_block;
    end
  end
endmodule

//--- hw/ubp_head_end.sv
`timescale 1ns/10ps
module ubp_head_end (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  ubp_link_if.head link
);
  ubp_pkg::ubp_tx_state_t state_reg;
  logic [31:0] ctrl_reg, off_reg, fec_reg, seed_reg, burst_reg, mode_reg, intlv_reg;
  logic refused_reg;
  logic [3:0] idx_reg;
  logic [1:0] phase_reg;
  logic valid_reg, last_reg;
  logic [7:0] data_reg;
  logic wr, start, refuse, busy;
  logic [2:0] bps;
  logic [15:0] v;
  logic [1:0] len;
  logic inc;
  logic [3:0] last_idx;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask);
    for (int b = 0; b < 4; b++)
      if (s_axi_wstrb[b])
        old[8*b +: 8] = s_axi_wdata[8*b +: 8];
    return old & mask;
  endfunction

  assign wr = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign busy = state_reg != ubp_pkg::TX_IDLE;
  assign start = wr && s_axi_awaddr == ubp_pkg::REG_CTRL && s_axi_wstrb[0]
    && s_axi_wdata[ubp_pkg::CTRL_START] && !busy;
  // A start is judged on the settings written with it, not on the previous ones
  assign bps = s_axi_wdata[6:4];
  // Offsets must be whole symbols; short grants need a nonzero burst cap
  assign refuse = bps == 3'h0 || off_reg[15:0] % 16'(bps) != 16'h0000
    || (s_axi_wdata[ubp_pkg::CTRL_SHORT] && burst_reg[7:0] == 8'h00);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ubp_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= wr;
      s_axi_wready <= wr;
      if (wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= s_axi_awaddr > ubp_pkg::REG_INTLV || s_axi_awaddr[1:0] != 2'h0
          ? ubp_pkg::RESP_SLVERR : ubp_pkg::RESP_OKAY;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Parameters hold still while a descriptor is going out
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= 32'h00000000;
      off_reg <= 32'h00000000;
      fec_reg <= 32'h00000000;
      seed_reg <= 32'h00000000;
      burst_reg <= 32'h00000000;
      mode_reg <= ubp_pkg::RST_MODE;
      intlv_reg <= 32'h00000000;
    end
    else if (wr && !busy)
    begin
      unique case (s_axi_awaddr)
        ubp_pkg::REG_CTRL: ctrl_reg <= merge(ctrl_reg, ubp_pkg::MASK_CTRL);
        ubp_pkg::REG_PRE_OFF: off_reg <= merge(off_reg, ubp_pkg::MASK_PRE_OFF);
        ubp_pkg::REG_FEC: fec_reg <= merge(fec_reg, ubp_pkg::MASK_FEC);
        ubp_pkg::REG_SEED: seed_reg <= merge(seed_reg, ubp_pkg::MASK_SEED);
        ubp_pkg::REG_BURST: burst_reg <= merge(burst_reg, ubp_pkg::MASK_HALF);
        ubp_pkg::REG_MODE: mode_reg <= merge(mode_reg, ubp_pkg::MASK_HALF);
        ubp_pkg::REG_INTLV: intlv_reg <= merge(intlv_reg, ubp_pkg::MASK_INTLV);
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ubp_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ubp_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          ubp_pkg::REG_CTRL: s_axi_rdata <= ctrl_reg;
          ubp_pkg::REG_STATUS: s_axi_rdata <= {30'h00000000, refused_reg, busy};
          ubp_pkg::REG_PRE_OFF: s_axi_rdata <= off_reg;
          ubp_pkg::REG_FEC: s_axi_rdata <= fec_reg;
          ubp_pkg::REG_SEED: s_axi_rdata <= seed_reg;
          ubp_pkg::REG_BURST: s_axi_rdata <= burst_reg;
          ubp_pkg::REG_MODE: s_axi_rdata <= mode_reg;
          ubp_pkg::REG_INTLV: s_axi_rdata <= intlv_reg;
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= ubp_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Attribute table walked by index; type code is 4 plus index
  always_comb
  begin
    len = (idx_reg == 4'h0 || idx_reg == 4'h3 || idx_reg == ubp_pkg::IDX_BLOCK) ? 2'h2 : 2'h1;
    inc = 1'b1;
    unique case (idx_reg)
      4'h0: v = off_reg[15:0];
      4'h1: v = {8'h00, fec_reg[7:0]};
      4'h2: v = {8'h00, fec_reg[15:8]};
      4'h3: v = {seed_reg[14:0], 1'b0};
      4'h4: v = {8'h00, burst_reg[7:0]};
      4'h5: v = {8'h00, burst_reg[15:8]};
      4'h6: v = {8'h00, mode_reg[7:0]};
      4'h7: v = {8'h00, mode_reg[15:8]};
      4'h8: v = {8'h00, intlv_reg[7:0]};
      default: v = intlv_reg[31:16];
    endcase
    // Guard choice for stable capacity is left to software
    if (idx_reg == ubp_pkg::IDX_GUARD)
      inc = !ctrl_reg[ubp_pkg::CTRL_CDMA];
    if (idx_reg >= ubp_pkg::IDX_DEPTH)
      inc = ctrl_reg[ubp_pkg::CTRL_EXT] && !ctrl_reg[ubp_pkg::CTRL_CDMA];
    last_idx = (ctrl_reg[ubp_pkg::CTRL_EXT] && !ctrl_reg[ubp_pkg::CTRL_CDMA])
      ? ubp_pkg::IDX_BLOCK : ubp_pkg::IDX_SCR;
  end

  // At least one idle cycle between bytes keeps the byte choice registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ubp_pkg::TX_IDLE;
      idx_reg <= 4'h0;
      phase_reg <= 2'h0;
      valid_reg <= 1'b0;
      last_reg <= 1'b0;
      data_reg <= 8'h00;
      refused_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ubp_pkg::TX_IDLE:
        begin
          idx_reg <= 4'h0;
          phase_reg <= 2'h0;
          if (start && refuse)
            refused_reg <= 1'b1;
          else if (start)
          begin
            refused_reg <= 1'b0;
            state_reg <= ubp_pkg::TX_LOAD;
          end
        end
        ubp_pkg::TX_LOAD:
        begin
          if (idx_reg == ubp_pkg::ATTR_COUNT)
            state_reg <= ubp_pkg::TX_IDLE;
          else if (!inc)
            idx_reg <= idx_reg + 4'h1;
          else
          begin
            valid_reg <= 1'b1;
            data_reg <= phase_reg == 2'h0 ? ubp_pkg::TYP_PRE_OFF + 8'(idx_reg)
              : phase_reg == 2'h1 ? 8'(len)
              : (phase_reg == 2'h2 && len == 2'h2) ? v[15:8] : v[7:0];
            last_reg <= idx_reg == last_idx && phase_reg == 2'(len + 2'h1);
            state_reg <= ubp_pkg::TX_SEND;
          end
        end
        ubp_pkg::TX_SEND:
        begin
          if (link.tx_ready)
          begin
            valid_reg <= 1'b0;
            last_reg <= 1'b0;
            state_reg <= last_reg ? ubp_pkg::TX_IDLE : ubp_pkg::TX_LOAD;
            if (phase_reg == 2'(len + 2'h1))
            begin
              phase_reg <= 2'h0;
              idx_reg <= idx_reg + 4'h1;
            end
            else
              phase_reg <= phase_reg + 2'h1;
          end
        end
        default:
          state_reg <= ubp_pkg::TX_IDLE;
      endcase
    end
  end

  assign link.tx_valid = valid_reg;
  assign link.tx_data = data_reg;
  assign link.tx_last = last_reg;
  assign link.ext_format = ctrl_reg[ubp_pkg::CTRL_EXT];
  assign link.code_div = ctrl_reg[ubp_pkg::CTRL_CDMA];
endmodule

//--- bench/ubp_link_asserts.sv
`timescale 1ns/10ps
module ubp_link_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic ext_format,
  input wire logic code_div,
  input wire logic cfg_valid,
  input wire logic cfg_error
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire logic take;
  assign take = tx_valid && tx_ready;
  // Bytes must not be dropped or altered while the decoder stalls
  a_valid_hold: assert property (tx_valid && !tx_ready |=> tx_valid)
    else $error("byte withdrawn before it was taken");
  a_data_hold: assert property (tx_valid && !tx_ready |=>
    $stable(tx_data) && $stable(tx_last))
    else $error("byte changed before it was taken");
  a_byte_gap: assert property (take |=> !tx_valid)
    else $error("bytes sent back to back");
  a_ready_drop: assert property (take && tx_last |=> !tx_ready)
    else $error("ready held after last byte");
  a_verdict_time: assert property (take && tx_last |-> ##2 (cfg_valid ^ cfg_error))
    else $error("no single verdict two cycles after last byte");
  a_verdict_cause: assert property ((cfg_valid || cfg_error) |-> $past(take && tx_last, 2))
    else $error("verdict without a finished descriptor");
  a_verdict_pulse: assert property (cfg_valid |=> !cfg_valid)
    else $error("config pulse longer than one cycle");
  // Format and channel kind decide the limits, so they must not move mid-descriptor
  a_mode_steady: assert property (tx_valid |-> $stable(ext_format) && $stable(code_div))
    else $error("format or channel kind changed during descriptor");
  c_accept: cover property (take && tx_last ##2 cfg_valid);
  c_reject: cover property (take && tx_last ##2 cfg_error);
  c_code_div: cover property (take && code_div);
endmodule

//--- bench/upstream_burst_profile_decoder_tb_top.sv
`timescale 1ns/10ps
module upstream_burst_profile_decoder_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic cfg_valid, cfg_error, cfg_fec_enable, cfg_scrambler_enable, cfg_burst_limit_enable;
  logic cfg_last_cw_shortened, cfg_interleave_dynamic;
  logic [15:0] cfg_preamble_start, interleave_block_size;
  logic [5:0] cfg_parity_bytes;
  logic [7:0] cfg_info_bytes, cfg_max_burst_minislots, cfg_guard_symbols, interleave_depth;
  logic [8:0] codeword_total_bytes;
  logic [14:0] cfg_scrambler_seed;
  int n_mismatch = 0;
  int n_compared = 0;

  always #5 aclk = ~aclk;

  ubp_link_if u_ubp_link_if ();
  ubp_head_end u_ubp_head_end (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link(u_ubp_link_if.head));
  ubp_burst_decoder u_ubp_burst_decoder (.aclk, .aresetn, .link(u_ubp_link_if.dev), .cfg_valid,
    .cfg_error, .cfg_preamble_start, .cfg_fec_enable, .cfg_parity_bytes, .cfg_info_bytes,
    .codeword_total_bytes, .cfg_scrambler_seed, .cfg_scrambler_enable, .cfg_burst_limit_enable,
    .cfg_max_burst_minislots, .cfg_guard_symbols, .cfg_last_cw_shortened,
    .cfg_interleave_dynamic, .interleave_depth, .interleave_block_size);
  ubp_link_asserts u_ubp_link_asserts (.aclk, .aresetn, .tx_valid(u_ubp_link_if.tx_valid),
    .tx_ready(u_ubp_link_if.tx_ready), .tx_data(u_ubp_link_if.tx_data),
    .tx_last(u_ubp_link_if.tx_last), .ext_format(u_ubp_link_if.ext_format),
    .code_div(u_ubp_link_if.code_div), .cfg_valid, .cfg_error);

  task complete_run;
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task tmo;
    n_mismatch++;
    $display("[FAIL] %0t no answer in time", $time);
    complete_run;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      n++;
      if (n > 100) tmo;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 100) tmo;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Polling status keeps the next start clear of a descriptor still in flight
  task idle;
    int n;
    n = 0;
    do
    begin
      rdr(ubp_pkg::REG_STATUS);
      n++;
      if (n > 50) tmo;
    end while (rd[0] !== 1'b0);
  endtask

  task go(input logic [31:0] fec, mode, intlv, ctrl, input logic ok);
    int n;
    n = 0;
    wr(ubp_pkg::REG_FEC, fec);
    wr(ubp_pkg::REG_MODE, mode);
    wr(ubp_pkg::REG_INTLV, intlv);
    wr(ubp_pkg::REG_CTRL, ctrl | 32'h1);
    do
    begin
      @(posedge aclk);
      n++;
      if (n > 400) tmo;
    end while (cfg_valid !== 1'b1 && cfg_error !== 1'b1);
    chk(32'(cfg_valid), 32'(ok));
    chk(32'(cfg_error), 32'(!ok));
    idle;
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(ubp_pkg::REG_MODE); chk(rd, ubp_pkg::RST_MODE);
    rdr(8'h20); chk(32'(rsp), 32'(ubp_pkg::RESP_SLVERR));
    wr(ubp_pkg::REG_PRE_OFF, 32'h64);
    wr(ubp_pkg::REG_SEED, 32'h5A5A);
    wr(ubp_pkg::REG_BURST, 32'h0905);
    go(32'hFD10, 32'h0202, 32'h7, 32'h42, 1'b1);
    chk(32'(cfg_preamble_start), 32'h64);
    chk(32'(cfg_parity_bytes), 32'h20);
    chk(32'(codeword_total_bytes), 32'h11D);
    chk(32'(cfg_scrambler_seed), 32'h5A5A);
    chk(32'(cfg_scrambler_enable), 32'h0);
    chk(32'(cfg_last_cw_shortened), 32'h1);
    chk(32'(cfg_burst_limit_enable), 32'h1);
    chk(32'(cfg_max_burst_minislots), 32'h5);
    chk(32'(cfg_guard_symbols), 32'h9);
    go(32'hFD10, 32'h0202, 32'h8, 32'h42, 1'b0);
    chk(32'(interleave_depth), 32'h7);
    go(32'hF008, 32'h0101, 32'h8, 32'h42, 1'b1);
    chk(32'(codeword_total_bytes), 32'h100);
    chk(32'(cfg_scrambler_enable), 32'h1);
    chk(32'(cfg_last_cw_shortened), 32'h0);
    go(32'hF008, 32'h0101, 32'h08010000, 32'h42, 1'b0);
    go(32'hF008, 32'h0101, 32'h08000000, 32'h42, 1'b1);
    chk(32'(cfg_interleave_dynamic), 32'h1);
    chk(32'(interleave_block_size), 32'h800);
    go(32'h100A, 32'h0101, 32'h0, 32'h40, 1'b1);
    go(32'h100B, 32'h0101, 32'h0, 32'h40, 1'b0);
    go(32'h1011, 32'h0101, 32'h0, 32'h42, 1'b0);
    go(32'h0F04, 32'h0101, 32'h0, 32'h42, 1'b0);
    go(32'hFE04, 32'h0101, 32'h0, 32'h42, 1'b0);
    go(32'h0F00, 32'h0101, 32'h0, 32'h42, 1'b1);
    chk(32'(cfg_fec_enable), 32'h0);
    chk(32'(cfg_info_bytes), 32'h0);
    chk(32'(cfg_parity_bytes), 32'h0);
    go(32'h1004, 32'h0101, 32'h0, 32'h46, 1'b1);
    chk(32'(cfg_guard_symbols), 32'h0);
    go(32'h1004, 32'h0103, 32'h0, 32'h42, 1'b0);
    go(32'h1004, 32'h0301, 32'h0, 32'h42, 1'b0);
    wr(ubp_pkg::REG_BURST, 32'h0900);
    wr(ubp_pkg::REG_CTRL, 32'h4B); idle; chk(32'(rd[1]), 32'h1);
    wr(ubp_pkg::REG_BURST, 32'h0905);
    wr(ubp_pkg::REG_PRE_OFF, 32'h6);
    wr(ubp_pkg::REG_CTRL, 32'h43); idle; chk(32'(rd[1]), 32'h1);
    wr(ubp_pkg::REG_PRE_OFF, 32'h64);
    wr(ubp_pkg::REG_CTRL, 32'h03); idle; chk(32'(rd[1]), 32'h1);
    go(32'h1004, 32'h0101, 32'h0, 32'h42, 1'b1); chk(32'(rd[1]), 32'h0);
    complete_run;
  end
endmodule
